/* hdl/dac_update_consts.svh */
// Purpose: timing counts and default codes for the DAC update control
// Assumes: 20 MHz system clock, 50 ns period
// Notes:   times are kept in ns, cycle counts derived from them
`ifndef DAC_UPDATE_CONSTS_SVH
`define DAC_UPDATE_CONSTS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_PERIOD_NS        50
`define RESET_SEQ_NS         300000
`define RESET_SEQ_CYC        (`RESET_SEQ_NS / `CLK_PERIOD_NS)
`define CHAN_CALC_NS         600
`define CHAN_CALC_CYC        (`CHAN_CALC_NS / `CLK_PERIOD_NS)
`define BUSY_TAIL_NS         300
`define BUSY_TAIL_CYC        (`BUSY_TAIL_NS / `CLK_PERIOD_NS)

// ****************************************************************
// default codes
// ****************************************************************
`define INPUT_DEFAULT        16'h8000
`define GAIN_DEFAULT         16'hFFFF
`define OFFSET_DEFAULT       16'h8000
`define GROUND_CODE          16'h8000

`endif

/* hdl/dac_update_pkg.sv */
// Purpose: shared types for the DAC update control
// Assumes: sixteen channels in two groups of eight
// Notes:   constants live in dac_update_consts.svh
package dac_update_pkg;

	typedef logic [15:0] word_t;
	typedef logic [15:0] chan_mask_t;

	// kind of word written by the host-side write port
	typedef enum logic [1:0] {
		WR_INPUT  = 2'b00,
		WR_GAIN   = 2'b01,
		WR_OFFSET = 2'b10,
		WR_BANK   = 2'b11
	} wr_kind_t;

	// calculation engine phases
	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_CALC = 2'b01,
		ENG_TAIL = 2'b10
	} eng_state_t;

endpackage : dac_update_pkg

/* hdl/calc_if.sv */
// Purpose: carrier between the update control and its calc engine
// Assumes: single clock domain
// Notes:   engine returns one computed word per channel step
`timescale 1ns/1ns
interface calc_if;
	import dac_update_pkg::*;
	logic       start;     // pulse: begin one channel computation
	logic [3:0] chan;
	logic       bank;      // 0 = word a, 1 = word b
	word_t      x;
	word_t      m;
	word_t      c;
	logic       done;      // pulse: result valid
	word_t      result;
	logic       busy;

	modport ctrl (output start, chan, bank, x, m, c,
		input done, result, busy);
	modport eng  (input start, chan, bank, x, m, c,
		output done, result, busy);
endinterface : calc_if

/* hdl/dac_calc_engine.sv */
// Purpose: shared multiplier computing one channel's computed word
// Assumes: one request at a time, start only when not busy
// Notes:   ends two cycles early so the hand-over fills the step time
`timescale 1ns/1ns
`include "dac_update_consts.svh"
module dac_calc_engine (
	// clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	// engine side of carrier
	calc_if.eng       eng
);
	import dac_update_pkg::*;

	localparam logic [4:0] STEP_CYC = 5'(`CHAN_CALC_CYC);

	logic [4:0]  cnt_r;
	logic        run_r;
	word_t       res_r;
	logic        done_r;
	logic [32:0] prod;
	logic [17:0] sum;

	// x*(m+1)/2^16 + c - 2^15, clamped to the code range
	assign prod = 33'(eng.x) * (33'(eng.m) + 33'h1);
	assign sum  = 18'(prod[32:16]) + 18'(eng.c) - 18'h8000;

	// one computation per step, result registered at the end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			cnt_r  <= 5'h00;
			run_r  <= 1'b0;
			res_r  <= 16'h0000;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (eng.start && !run_r) begin
				run_r <= 1'b1;
				cnt_r <= STEP_CYC - 5'h02;
			end else if (run_r) begin
				if (cnt_r == 5'h01) begin
					run_r  <= 1'b0;
					done_r <= 1'b1;
					// negative sums clamp to zero, overflow to full scale
					res_r  <= sum[17] ? 16'h0000 :
						(sum[16] ? 16'hFFFF : sum[15:0]);
				end
				cnt_r <= cnt_r - 5'h01;
			end
		end
	end

	assign eng.done   = done_r;
	assign eng.result = res_r;
	assign eng.busy   = run_r;
endmodule : dac_calc_engine

/* hdl/dac_update_ctrl.sv */
// Purpose: update control for a sixteen channel voltage-output DAC
// Assumes: write port already decoded from the serial frame, same clock
// Notes:   pins from outside pass two flip-flops before use
`timescale 1ns/1ns
`include "dac_update_consts.svh"
module dac_update_ctrl (
	// clock and reset
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_rst_n,
	// device pins
	input  wire logic                      i_reset_pin_n,
	input  wire logic                      i_output_clear_n,
	input  wire logic                      i_load_outputs_n,
	input  wire logic                      i_busy_n,
	output logic                           o_busy_n,
	output logic                           o_busy_oe,
	// decoded write port
	input  wire logic                      i_wr_valid,
	input  dac_update_pkg::wr_kind_t       i_wr_kind,
	input  dac_update_pkg::chan_mask_t     i_wr_chans,
	input  wire logic                      i_wr_bank,
	input  dac_update_pkg::word_t          i_wr_data,
	// status and outputs
	output logic                           o_reset_active,
	output logic                           o_ground_sel,
	output dac_update_pkg::word_t          o_dac_code [16]
);
	import dac_update_pkg::*;

	localparam logic [12:0] RESET_CYC = 13'(`RESET_SEQ_CYC);
	localparam logic [4:0]  STEP_CYC  = 5'(`CHAN_CALC_CYC);
	localparam logic [4:0]  TAIL_CYC  = 5'(`BUSY_TAIL_CYC);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic       rst_pin_d_r;
	logic       load_d_r;
	logic       busy_d_r;

	// first stage read only by the second
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			sync1_r <= 4'hF;
			sync2_r <= 4'hF;
		end else begin
			sync1_r <= {i_reset_pin_n, i_output_clear_n,
				i_load_outputs_n, i_busy_n};
			sync2_r <= sync1_r;
		end
	end

	logic rst_pin_s;
	logic clear_s_n;
	logic load_s_n;
	logic busy_line_s_n;
	assign rst_pin_s     = sync2_r[3];
	assign clear_s_n     = sync2_r[2];
	assign load_s_n      = sync2_r[1];
	assign busy_line_s_n = sync2_r[0];

	// edge history for reset pin, load and shared busy line
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			rst_pin_d_r <= 1'b1;
			load_d_r    <= 1'b1;
			busy_d_r    <= 1'b1;
		end else begin
			rst_pin_d_r <= rst_pin_s;
			load_d_r    <= load_s_n;
			busy_d_r    <= busy_line_s_n;
		end
	end

	logic rst_rise;
	logic load_fall;
	logic busy_rise;
	assign rst_rise  = rst_pin_s && !rst_pin_d_r;
	assign load_fall = !load_s_n && load_d_r;
	assign busy_rise = busy_line_s_n && !busy_d_r;

	// ************************************************************
	// reset sequence
	// ************************************************************
	logic [12:0] rst_cnt_r;
	logic        rst_busy;
	assign rst_busy = (rst_cnt_r != 13'h0000);

	// counts out the default-restore interval after a rising edge
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n)
			rst_cnt_r <= 13'h0000;
		else if (rst_rise)
			rst_cnt_r <= RESET_CYC;
		else if (rst_busy)
			rst_cnt_r <= rst_cnt_r - 13'h0001;
	end
	assign o_reset_active = rst_busy;

	// ************************************************************
	// word storage
	// ************************************************************
	word_t      in_a_r  [16];
	word_t      in_b_r  [16];
	word_t      gain_a_r[16];
	word_t      gain_b_r[16];
	word_t      offs_a_r[16];
	word_t      offs_b_r[16];
	word_t      comp_a_r[16];
	word_t      comp_b_r[16];
	word_t      dac_r   [16];
	logic [15:0] bank_sel_r;
	chan_mask_t pend_a_r;
	chan_mask_t pend_b_r;
	chan_mask_t dirty_r;

	logic    wr_word;
	logic    wr_bank;
	assign wr_word = i_wr_valid && (i_wr_kind != WR_BANK);
	assign wr_bank = i_wr_valid && (i_wr_kind == WR_BANK);

	// ************************************************************
	// calculation engine
	// ************************************************************
	calc_if cif ();
	dac_calc_engine u_eng (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.eng       (cif.eng)
	);

	eng_state_t  st_r;
	logic [4:0]  tail_r;
	logic [3:0]  cur_chan_r;
	logic        cur_bank_r;
	logic        issued_r;
	logic        any_pend;
	logic [3:0]  next_chan;
	logic        next_bank;

	assign any_pend = (pend_a_r != 16'h0000) || (pend_b_r != 16'h0000);

	// lowest channel with word a pending, else lowest channel with word b pending
	always_comb begin
		next_chan = 4'h0;
		next_bank = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (pend_b_r[i]) begin
				next_chan = 4'(i);
				next_bank = 1'b1;
			end
		end
		for (int i = 15; i >= 0; i--) begin
			if (pend_a_r[i]) begin
				next_chan = 4'(i);
				next_bank = 1'b0;
			end
		end
	end

	assign cif.start = (st_r == ENG_CALC) && !issued_r && !cif.busy &&
		any_pend;
	assign cif.chan  = cur_chan_r;
	assign cif.bank  = cur_bank_r;
	assign cif.x     = cur_bank_r ? in_b_r[cur_chan_r]
		: in_a_r[cur_chan_r];
	assign cif.m     = cur_bank_r ? gain_b_r[cur_chan_r]
		: gain_a_r[cur_chan_r];
	assign cif.c     = cur_bank_r ? offs_b_r[cur_chan_r]
		: offs_a_r[cur_chan_r];

	// one step per channel, then one extra step plus the tail;
	// this gives (n+1)*600 ns + 300 ns of busy
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || rst_rise) begin
			st_r       <= ENG_IDLE;
			tail_r     <= 5'h00;
			cur_chan_r <= 4'h0;
			cur_bank_r <= 1'b0;
			issued_r   <= 1'b0;
		end else begin
			unique case (st_r)
				ENG_IDLE: begin
					if (wr_word || any_pend)
						st_r <= ENG_CALC;
					else if (wr_bank) begin
						st_r   <= ENG_TAIL;
						tail_r <= STEP_CYC;
					end
				end
				ENG_CALC: begin
					if (cif.start) begin
						issued_r   <= 1'b1;
						cur_chan_r <= next_chan;
						cur_bank_r <= next_bank;
					end else if (cif.done)
						issued_r <= 1'b0;
					else if (!issued_r && !any_pend && !cif.busy) begin
						st_r   <= ENG_TAIL;
						tail_r <= STEP_CYC + TAIL_CYC - 5'h01;
					end
				end
				ENG_TAIL: begin
					if (any_pend)
						st_r <= ENG_CALC;
					else if (tail_r > 5'h01)
						tail_r <= tail_r - 5'h01;
					else if (wr_bank)
						tail_r <= STEP_CYC;
					else if (!wr_word)
						st_r <= ENG_IDLE;
				end
				default: st_r <= ENG_IDLE;
			endcase
		end
	end

	logic busy_own;
	assign busy_own = (st_r != ENG_IDLE) || rst_busy;

	// open-drain busy: drive low while computing or during the reset sequence
	assign o_busy_n  = 1'b0;
	assign o_busy_oe = busy_own;

	// ************************************************************
	// load handling
	// ************************************************************
	logic load_pend_r;
	logic line_busy;
	logic apply;
	assign line_busy = busy_own || !busy_line_s_n;
	assign apply = !line_busy && clear_s_n &&
		(load_pend_r || (!load_s_n && (busy_rise || load_fall)));

	// falling load while busy is remembered; clear discards it
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !clear_s_n)
			load_pend_r <= 1'b0;
		else if (apply)
			load_pend_r <= 1'b0;
		else if (load_fall && line_busy)
			load_pend_r <= 1'b1;
	end

	// ************************************************************
	// per-channel storage and dac registers
	// ************************************************************
	generate
		for (genvar ch = 0; ch < 16; ch++) begin : g_chan
			logic hit;
			logic done_a;
			logic done_b;
			logic take_a;
			logic take_b;
			assign hit    = wr_word && i_wr_chans[ch];
			assign take_a = cif.start && next_chan == 4'(ch) && !next_bank;
			assign take_b = cif.start && next_chan == 4'(ch) && next_bank;
			assign done_a = cif.done && cif.chan == 4'(ch) && !cif.bank;
			assign done_b = cif.done && cif.chan == 4'(ch) && cif.bank;

			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_n || rst_rise) begin
					in_a_r[ch]   <= `INPUT_DEFAULT;
					in_b_r[ch]   <= `INPUT_DEFAULT;
					gain_a_r[ch] <= `GAIN_DEFAULT;
					gain_b_r[ch] <= `GAIN_DEFAULT;
					offs_a_r[ch] <= `OFFSET_DEFAULT;
					offs_b_r[ch] <= `OFFSET_DEFAULT;
					comp_a_r[ch] <= `GROUND_CODE;
					comp_b_r[ch] <= `GROUND_CODE;
					dac_r[ch]    <= `GROUND_CODE;
					bank_sel_r[ch] <= 1'b0;
					pend_a_r[ch] <= 1'b0;
					pend_b_r[ch] <= 1'b0;
					dirty_r[ch]  <= 1'b0;
				end else begin
					if (hit && i_wr_kind == WR_INPUT) begin
						if (i_wr_bank) in_b_r[ch] <= i_wr_data;
						else           in_a_r[ch] <= i_wr_data;
					end
					if (hit && i_wr_kind == WR_GAIN) begin
						if (i_wr_bank) gain_b_r[ch] <= i_wr_data;
						else           gain_a_r[ch] <= i_wr_data;
					end
					if (hit && i_wr_kind == WR_OFFSET) begin
						if (i_wr_bank) offs_b_r[ch] <= i_wr_data;
						else           offs_a_r[ch] <= i_wr_data;
					end
					// cleared at issue so a mid-step write reruns
					pend_a_r[ch] <= (hit && !i_wr_bank) ||
						(pend_a_r[ch] && !take_a);
					pend_b_r[ch] <= (hit && i_wr_bank) ||
						(pend_b_r[ch] && !take_b);
					if (done_a) comp_a_r[ch] <= cif.result;
					if (done_b) comp_b_r[ch] <= cif.result;
					if (wr_bank && i_wr_chans[ch])
						bank_sel_r[ch] <= i_wr_data[ch % 8];
					// only changed channels move on a load
					if (apply) begin
						if (dirty_r[ch])
							dac_r[ch] <= bank_sel_r[ch] ?
								comp_b_r[ch] : comp_a_r[ch];
						dirty_r[ch] <= done_a || done_b;
					end else if (done_a || done_b)
						dirty_r[ch] <= 1'b1;
				end
			end
			assign o_dac_code[ch] = dac_r[ch];
		end
	endgenerate

	// clear grounds outputs without touching any word or dac register
	assign o_ground_sel = !clear_s_n;
endmodule : dac_update_ctrl

/* verif/dac_update_ctrl_monitor.sv */
// Purpose: port assertions for the dac update control
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound onto every dac_update_ctrl instance
`timescale 1ns/1ns
`include "dac_update_consts.svh"
module dac_update_ctrl_monitor (
	input wire logic            i_clk_sys,
	input wire logic            i_rst_n,
	input wire logic            i_reset_pin_n,
	input wire logic            i_output_clear_n,
	input wire logic            i_busy_n,
	input wire logic            i_wr_valid,
	input wire logic            o_busy_oe,
	input wire logic            o_reset_active,
	input wire logic            o_ground_sel,
	input dac_update_pkg::word_t o_dac_code [16]
);
	import dac_update_pkg::*;
	// longest legal busy: sixteen channels plus one step and the tail
	localparam int BUSY_MAX = 17 * `CHAN_CALC_CYC + `BUSY_TAIL_CYC;
	localparam int RST_CYC  = `RESET_SEQ_CYC;
	logic [255:0] flat;
	logic [8:0]   bcnt_r;
	logic [12:0]  rcnt_r;
	// all codes in one vector so one stability test sees them all
	always_comb begin
		for (int i = 0; i < 16; i++) flat[i*16 +: 16] = o_dac_code[i];
	end
	// busy outside the reset sequence and reset sequence lengths
	always_ff @(posedge i_clk_sys) begin
		bcnt_r <= (o_busy_oe && !o_reset_active) ? bcnt_r + 9'h001 : 9'h000;
		rcnt_r <= o_reset_active ? rcnt_r + 13'h0001 : 13'h0000;
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	property p_busy_start;
		i_wr_valid && !o_reset_active |=> o_busy_oe;
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("busy not raised after a write");
	property p_busy_max;
		bcnt_r <= BUSY_MAX;
	endproperty
	a_busy_max: assert property (p_busy_max)
		else $error("busy pulse too long");
	property p_no_upd_busy;
		!$stable(flat) && !o_reset_active && !$past(o_reset_active)
			|-> !$past(o_busy_oe);
	endproperty
	a_no_upd_busy: assert property (p_no_upd_busy)
		else $error("dac code changed while busy");
	property p_clr_gnd;
		(!i_output_clear_n)[*4] |-> o_ground_sel;
	endproperty
	a_clr_gnd: assert property (p_clr_gnd)
		else $error("clear low but outputs not grounded");
	property p_clr_hold;
		o_ground_sel && $past(o_ground_sel) |-> $stable(flat);
	endproperty
	a_clr_hold: assert property (p_clr_hold)
		else $error("dac code changed during clear");
	property p_ext_busy;
		(!i_busy_n)[*3] |-> $stable(flat);
	endproperty
	a_ext_busy: assert property (p_ext_busy)
		else $error("dac code changed while busy wire low");
	property p_rst_start;
		$rose(i_reset_pin_n) |-> ##[1:5] o_reset_active;
	endproperty
	a_rst_start: assert property (p_rst_start)
		else $error("reset sequence not started");
	property p_rst_len;
		rcnt_r <= RST_CYC;
	endproperty
	a_rst_len: assert property (p_rst_len)
		else $error("reset sequence too long");
endmodule : dac_update_ctrl_monitor

bind dac_update_ctrl dac_update_ctrl_monitor u_mon (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
	.i_reset_pin_n(i_reset_pin_n), .i_output_clear_n(i_output_clear_n),
	.i_busy_n(i_busy_n), .i_wr_valid(i_wr_valid), .o_busy_oe(o_busy_oe),
	.o_reset_active(o_reset_active), .o_ground_sel(o_ground_sel),
	.o_dac_code(o_dac_code)
);

/* verif/dac_host_model.sv */
// Purpose: host side of the reset, clear, load and busy pins
// Assumes: pins change just after the falling clock edge
// Notes:   busy wire has a pull-up; any party may hold it low
`timescale 1ns/1ns
module dac_host_model (
	// clock and device busy drive
	input  wire logic i_clk_sys,
	input  wire logic i_busy_oe,
	// pins toward the device
	output logic      o_reset_pin_n,
	output logic      o_output_clear_n,
	output logic      o_load_outputs_n,
	output logic      o_busy_wire
);
	logic hold_r; // another device still computing
	// reset pin high from time zero so the words start clean
	initial begin
		o_reset_pin_n    = 1'b1;
		o_output_clear_n = 1'b1;
		o_load_outputs_n = 1'b1;
		hold_r           = 1'b0;
	end
	// wired pull-downs against the pull-up
	assign o_busy_wire = !(i_busy_oe || hold_r);
	// new pin levels; caller keeps clear low around span changes
	task pins(input logic r, input logic c, input logic l, input logic h);
		@(negedge i_clk_sys);
		o_reset_pin_n    = r;
		o_output_clear_n = c;
		o_load_outputs_n = l;
		hold_r           = h;
	endtask : pins
endmodule : dac_host_model

/* verif/multichannel_dac_update_control_test.sv */
// Purpose: self-checking bench for the dac update control
// Assumes: 20 MHz clock, bench drives on the falling edge
// Notes:   reset sequence runs at full length, about 6000 cycles
`timescale 1ns/1ns
`include "dac_update_consts.svh"
module multichannel_dac_update_control_test;
	import dac_update_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rst_n = 1'b0;
	logic         wr_valid = 1'b0;
	wr_kind_t     wr_kind = WR_INPUT;
	chan_mask_t   wr_chans = 16'h0000;
	logic         wr_bank = 1'b0;
	word_t        wr_data = 16'h0000;
	logic         busy_oe, busy_drv_n, reset_active, ground_sel;
	logic         reset_pin_n, clear_n, load_n, busy_wire;
	word_t        dac [16];
	word_t        exp_r [16];
	logic [255:0] q [$];
	logic [255:0] prev_r = '0;
	logic         rp = 1'b1, cl = 1'b1, hb = 1'b0;
	integer       seed = 32'h25c8bc60;
	int           n_mismatch = 0, samples_checked = 0, cyc = 0;

	always #25 clk_sys = ~clk_sys;

	dac_update_ctrl u_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
		.i_reset_pin_n(reset_pin_n), .i_output_clear_n(clear_n),
		.i_load_outputs_n(load_n), .i_busy_n(busy_wire),
		.o_busy_n(busy_drv_n), .o_busy_oe(busy_oe), .i_wr_valid(wr_valid),
		.i_wr_kind(wr_kind), .i_wr_chans(wr_chans), .i_wr_bank(wr_bank),
		.i_wr_data(wr_data), .o_reset_active(reset_active),
		.o_ground_sel(ground_sel), .o_dac_code(dac));
	dac_host_model u_host (.i_clk_sys(clk_sys), .i_busy_oe(busy_oe),
		.o_reset_pin_n(reset_pin_n), .o_output_clear_n(clear_n),
		.o_load_outputs_n(load_n), .o_busy_wire(busy_wire));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [255:0] pk(input word_t a [16]);
		logic [255:0] f;
		for (int i = 0; i < 16; i++) f[i*16 +: 16] = a[i];
		return f;
	endfunction : pk
	task chk(input logic [255:0] got, input logic [255:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk
	// widths are counted here, so a range check is enough
	task chk_rng(input logic [15:0] got, input int lo, input int hi);
		samples_checked++;
		if ($isunknown(got) || got < lo || got > hi) begin
			$display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
			n_mismatch++;
		end
	endtask : chk_rng
	task results();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	task settle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : settle
	task wr(input wr_kind_t k, input chan_mask_t m, input logic b,
		input word_t d);
		@(negedge clk_sys);
		wr_valid = 1'b1;
		wr_kind = k;
		wr_chans = m;
		wr_bank = b;
		wr_data = d;
		@(negedge clk_sys);
		wr_valid = 1'b0;
	endtask : wr
	task hp(input logic l);
		u_host.pins(rp, cl, l, hb);
	endtask : hp
	task ld();
		hp(1'b0);
		settle(2);
		hp(1'b1);
	endtask : ld
	// bounded wait for a level, then its width in cycles
	task automatic meas(input bit rs, output logic [15:0] w);
		int k;
		k = 0;
		w = 16'h0000;
		while ((rs ? reset_active : busy_oe) !== 1'b1 && k < 10) begin
			@(negedge clk_sys);
			k++;
		end
		while ((rs ? reset_active : busy_oe) === 1'b1 && w < 16'h2000) begin
			@(negedge clk_sys);
			w++;
		end
	endtask : meas
	task done_t(input string s);
		for (int k = 0; k < 60 && q.size() != 0; k++) @(negedge clk_sys);
		$display("test %s done", s);
	endtask : done_t

	// output watcher: every code change must match the oldest note
	always @(negedge clk_sys) begin
		if (rst_n && pk(dac) !== prev_r) begin
			if (q.size() == 0) chk(pk(dac), prev_r);
			else chk(pk(dac), q.pop_front());
		end
		prev_r = pk(dac);
	end
	// hang guard, well above the expected run of about 6700 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		chan_mask_t  mk [4];
		int          nc [4];
		int          lo;
		word_t       d;
		logic [15:0] w;
		longint      m, c;
		mk = '{16'h0001, 16'h0808, 16'hFF00, 16'hFFFF};
		nc = '{1, 2, 8, 16};
		for (int i = 0; i < 16; i++) exp_r[i] = `GROUND_CODE;
		settle(10);
		rst_n = 1'b1;
		settle(2);
		chk(pk(dac), pk(exp_r));
		chk(256'(busy_drv_n), 256'h0);
		// reset pin held low must not disturb the writes
		rp = 1'b0;
		hp(1'b1);
		for (int i = 0; i < 4; i++) begin
			d = word_t'($random(seed));
			wr(WR_INPUT, mk[i], 1'b0, d);
			meas(0, w);
			lo = (nc[i] + 1) * `CHAN_CALC_CYC;
			chk_rng(w, lo, lo + `BUSY_TAIL_CYC);
			for (int j = 0; j < 16; j++) if (mk[i][j]) exp_r[j] = d;
			q.push_back(pk(exp_r));
			ld();
		end
		done_t("masks");
		// rising reset edge: defaults back and outputs at ground
		for (int i = 0; i < 16; i++) exp_r[i] = `GROUND_CODE;
		q.push_back(pk(exp_r));
		rp = 1'b1;
		hp(1'b1);
		meas(1, w);
		chk_rng(w, `RESET_SEQ_CYC, `RESET_SEQ_CYC + 1);
		meas(0, w);
		done_t("reset");
		// calibration on default input, load issued while busy
		m = 64'hFFFF - 164;
		c = 64'h8000 + 98;
		wr(WR_GAIN, 16'h0020, 1'b0, word_t'(m));
		wr(WR_OFFSET, 16'h0020, 1'b0, word_t'(c));
		exp_r[5] = word_t'(((64'h8000 * (m + 1)) >> 16) + c - 64'h8000);
		q.push_back(pk(exp_r));
		ld();
		meas(0, w);
		done_t("calibration");
		// word b then bank select for one channel
		d = word_t'($random(seed));
		wr(WR_INPUT, 16'h0004, 1'b1, d);
		meas(0, w);
		wr(WR_BANK, 16'h00FF, 1'b0, 16'h0004);
		meas(0, w);
		chk_rng(w, `CHAN_CALC_CYC, `CHAN_CALC_CYC);
		exp_r[2] = d;
		q.push_back(pk(exp_r));
		ld();
		done_t("bank");
		// other device holds busy: the load waits for release
		hb = 1'b1;
		hp(1'b1);
		exp_r[6] = word_t'($random(seed));
		exp_r[7] = word_t'($random(seed));
		wr(WR_INPUT, 16'h0040, 1'b0, exp_r[6]);
		wr(WR_INPUT, 16'h0080, 1'b0, exp_r[7]);
		ld();
		meas(0, w);
		settle(20);
		q.push_back(pk(exp_r));
		hb = 1'b0;
		hp(1'b1);
		done_t("shared busy");
		// clear: grounded, load ignored, codes kept
		cl = 1'b0;
		hp(1'b1);
		settle(4);
		chk(256'(ground_sel), 256'h1);
		d = word_t'($random(seed));
		wr(WR_INPUT, 16'h0001, 1'b0, d);
		meas(0, w);
		ld();
		settle(10);
		cl = 1'b1;
		hp(1'b1);
		settle(6);
		chk(256'(ground_sel), 256'h0);
		exp_r[0] = d;
		q.push_back(pk(exp_r));
		ld();
		done_t("clear");
		// load held low: update as soon as busy ends
		hp(1'b0);
		exp_r[15] = word_t'($random(seed));
		q.push_back(pk(exp_r));
		wr(WR_INPUT, 16'h8000, 1'b0, exp_r[15]);
		meas(0, w);
		settle(6);
		hp(1'b1);
		done_t("load held");
		results();
	end
endmodule : multichannel_dac_update_control_test
